// ---- bench/its_core_model.sv ----
// Core sequencer model: takes standing requests after a set wait.
`timescale 1ns/1ps
`default_nettype none
module its_core_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Request side and wait setting.
	input wire logic irq_req,
	input wire logic [3:0] ack_wait,
	// Service pulse.
	output logic irq_ack
);
	// ==============================
	// Wait counter; a slow core lets a request stand before taking it.
	logic [3:0] cnt;
	// One-cycle service pulse, only on a request that still stands.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 4'h0;
			irq_ack <= 1'b0;
		end else if (irq_req && !irq_ack && cnt == ack_wait) begin
			irq_ack <= 1'b1;
			cnt <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			cnt <= (irq_req && !irq_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/its_irq_ctrl_tb_top.sv ----
// Self-checking bench of the interrupt source and time base block.
`timescale 1ns/1ps
`default_nettype none
module its_irq_ctrl_tb_top;
	// ==============================
	// Stimulus, observed outputs and the flag model.
	logic clk = 1'b0, resetn = 1'b0, sub_clk = 1'b0, high_clk = 1'b0;
	logic [3:0] reg_addr = 4'h0, ack_wait = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, irq_vector, rd_v;
	logic reg_we = 1'b0, reg_re = 1'b0, ext_irq_pin = 1'b0, stack_full = 1'b0, return_from_irq_instr = 1'b0;
	logic [11:0] evt = 12'h000, exp_flag = 12'h000; // Event pulses and modelled flags.
	logic ext_pull_high, irq_ack, irq_req, wake, irq;
	int n_errors = 0, checks_done = 0, i, k, w;
	localparam logic [11:0] EVM = 12'hfbc; // Sources raised by peripheral pulses.
	// Time base cases: control, source, expected period in cycles.
	localparam logic [7:0] TB_C [6] = '{8'h08, 8'h90, 8'h08, 8'h80, 8'h08, 8'hf0};
	localparam logic [7:0] TB_P [6] = '{8'h00, 8'h00, 8'h01, 8'h30, 8'h02, 8'h00};
	localparam int TB_T [6] = '{256, 512, 1024, 1024, 2048, 32768};
	// ==============================
	// Clocks: high clock at a quarter, sub clock at an eighth of the system rate.
	always #2.5 clk = ~clk;
	always #10 high_clk = ~high_clk;
	always #20 sub_clk = ~sub_clk;
	// ==============================
	// Design, and the core that services it.
	its_irq_ctrl u_its_irq_ctrl (
		.clk(clk), .resetn(resetn), .ce(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .ext_pull_high(ext_pull_high),
		.sub_clk(sub_clk), .high_clk(high_clk),
		.adc_done(evt[its_pkg::S_AD]), .lvd_low(evt[its_pkg::S_LVD]),
		.nv_write_done(evt[its_pkg::S_NV]), .ctm_p_match(evt[its_pkg::S_CTP]),
		.ctm_a_match(evt[its_pkg::S_CTA]),
		.ptm_p_match({evt[its_pkg::S_PTP2], evt[its_pkg::S_PTP1]}),
		.ptm_a_match({evt[its_pkg::S_PTA2], evt[its_pkg::S_PTA1]}),
		.stack_full(stack_full), .irq_ack(irq_ack), .return_from_irq_instr(return_from_irq_instr), .irq_req(irq_req),
		.irq_vector(irq_vector), .wake(wake), .irq(irq)
	);
	its_core_model u_its_core_model (
		.clk(clk), .resetn(resetn), .irq_req(irq_req), .ack_wait(ack_wait), .irq_ack(irq_ack)
	);
	// ==============================
	// Comparison, bus cycles and event helpers.
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] expv);
		checks_done++;
		if (seen !== expv) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, expv, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample mid-cycle.
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		rd_v = reg_rdata;
	endtask
	task automatic chk_flags();
		logic [11:0] f;
		rd(its_pkg::A_FLAG_LO);
		f[7:0] = rd_v;
		rd(its_pkg::A_FLAG_HI);
		f[11:8] = rd_v[3:0];
		chk("flags", f, exp_flag);
	endtask
	// Flags clear by writing ones.
	task automatic clr();
		wr(its_pkg::A_FLAG_LO, 8'hff);
		wr(its_pkg::A_FLAG_HI, 8'h0f);
		exp_flag = 12'h000;
	endtask
	// Wake is due only where some flag newly rises.
	task automatic pulse(input logic [11:0] m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= 12'h000;
		@(negedge clk);
		chk("wake", {11'h0, wake}, {11'h0, |(m & ~exp_flag)});
		exp_flag = exp_flag | m;
	endtask
	function automatic int lowest(input logic [11:0] f);
		int j;
		lowest = 0;
		for (j = 11; j >= 0; j--) begin
			if (f[j]) begin
				lowest = j;
			end
		end
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==============================
	// Watchdog: the longest time base case sets the span.
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	// ==============================
	// Main sequence.
	initial begin
		void'($urandom(32'ha57082e6));
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		// Reset values, the unmapped index and reserved bits.
		for (i = 0; i < 8; i++) begin
			rd(i[3:0]);
			chk("reset value", {4'h0, rd_v}, 12'h000);
		end
		wr(its_pkg::A_PSC, 8'hff);
		rd(its_pkg::A_PSC);
		chk("prescaler source", {4'h0, rd_v}, 12'h033);
		wr(its_pkg::A_TBC, 8'h77);
		rd(its_pkg::A_TBC);
		chk("time base control", {4'h0, rd_v}, 12'h077);
		wr(its_pkg::A_TBC, 8'h00);
		wr(its_pkg::A_PSC, 8'h00);
		$display("test registers done");
		// Each event twice with enables off: the second must not wake again.
		for (i = 0; i < 12; i++) begin
			if (EVM[i]) begin
				pulse(12'h001 << i);
				pulse(12'h001 << i);
			end
		end
		chk("irq", {11'h0, irq}, 12'h000);
		chk_flags();
		$display("test events done");
		// Every edge code, both pin directions, pull-high toggled alongside.
		for (i = 0; i < 4; i++) begin
			clr();
			wr(its_pkg::A_CTRL, {4'h0, i[0], i[1:0], 1'b0});
			@(negedge clk);
			chk("pull high", {11'h0, ext_pull_high}, {11'h0, i[0]});
			@(posedge clk);
			ext_irq_pin <= 1'b1;
			repeat (6) @(posedge clk);
			exp_flag[0] = (i == 1 || i == 3);
			chk_flags();
			clr();
			@(posedge clk);
			ext_irq_pin <= 1'b0;
			repeat (6) @(posedge clk);
			exp_flag[0] = (i >= 2);
			chk_flags();
		end
		$display("test external pin done");
		// Random simultaneous requests, served in priority order by a core of random speed.
		clr();
		wr(its_pkg::A_EN_LO, 8'hff);
		wr(its_pkg::A_EN_HI, 8'h0f);
		// The pin joins the batch, so its top priority is tried against the rest.
		@(posedge clk);
		ext_irq_pin <= 1'b1;
		repeat (6) @(posedge clk);
		exp_flag[its_pkg::S_EXT] = 1'b1;
		pulse((12'($urandom) & EVM) | 12'h400);
		@(posedge clk);
		stack_full <= 1'b1;
		wr(its_pkg::A_CTRL, 8'h01);
		repeat (4) @(negedge clk);
		chk("request with full stack", {11'h0, irq_req}, 12'h000);
		@(posedge clk);
		stack_full <= 1'b0;
		while (exp_flag != 12'h000) begin
			ack_wait <= 4'($urandom_range(0, 9));
			for (k = 0; k < 40 && irq_ack !== 1'b1; k++) @(negedge clk);
			w = lowest(exp_flag);
			chk("vector", {4'h0, irq_vector}, {4'h0, its_pkg::VEC[w]});
			chk("irq", {11'h0, irq}, 12'h001);
			exp_flag[w] = 1'b0;
			@(negedge clk);
			chk("request after service", {11'h0, irq_req}, 12'h000);
			chk_flags();
			rd(its_pkg::A_CTRL);
			chk("global enable", {4'h0, rd_v}, 12'h000);
			@(posedge clk);
			return_from_irq_instr <= 1'b1;
			@(posedge clk);
			return_from_irq_instr <= 1'b0;
		end
		rd(its_pkg::A_CTRL);
		chk("global enable after return", {4'h0, rd_v}, 12'h001);
		$display("test service done");
		// Time bases: each source, periods of two-power 8, 9 and 15; the idle base must stay silent.
		wr(its_pkg::A_CTRL, 8'h00);
		for (i = 0; i < 6; i++) begin
			wr(its_pkg::A_TBC, 8'h00);
			clr();
			wr(its_pkg::A_PSC, TB_P[i]);
			wr(its_pkg::A_TBC, TB_C[i]);
			repeat (TB_T[i] * 15 / 16) @(posedge clk);
			chk_flags();
			repeat (TB_T[i] / 8) @(posedge clk);
			exp_flag = TB_C[i][7] ? 12'h040 : 12'h002;
			chk_flags();
		end
		wr(its_pkg::A_TBC, 8'h00);
		$display("test time base done");
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- verilog/its_irq_ctrl.sv ----
// Interrupt sources, request flags, priority and two time bases.
//
// Contract
// - Configured pin edge sets external request flag.
// - Edge select: rising, falling, both, or off.
// - Branch needs global, own enable, stack free.
// - Service clears source flag and global enable.
// - Pin pull-high stays valid as interrupt input.
// - Conversion done sets converter flag.
// - Time base overflow sets its flag.
// - Each 15-bit prescaler picks one of four clocks.
// - Time base runs only with its run bit.
// - Time base 1 period two-power eight to fifteen.
// - Timer comparator matches set P and A flags.
// - Nonvolatile write end sets its flag.
// - Low supply report sets its flag.
// - Fixed vectors; external pin highest priority.
// - Any flag rising wakes device, enables ignored.
// - Flags stay set until serviced or cleared.
// - Return-from-interrupt sets global enable again.
`default_nettype none
`timescale 1ns/1ps
module its_irq_ctrl (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	// External pin and its pull-high control.
	input wire logic ext_irq_pin,
	output logic ext_pull_high,
	// Prescaler clocks from outside this domain.
	input wire logic sub_clk,
	input wire logic high_clk,
	// Peripheral events, same-clock pulses (low supply is a level).
	input wire logic adc_done,
	input wire logic lvd_low,
	input wire logic nv_write_done,
	input wire logic ctm_p_match,
	input wire logic ctm_a_match,
	input wire logic [1:0] ptm_p_match,
	input wire logic [1:0] ptm_a_match,
	// Core sequencer.
	input wire logic stack_full,
	input wire logic irq_ack,
	input wire logic return_from_irq_instr,
	output logic irq_req,
	output logic [7:0] irq_vector,
	output logic wake,
	output logic irq
);
	// ==============================
	// State.
	logic [its_pkg::NSRC-1:0] flag, next_flag; // Sticky request flags.
	logic [its_pkg::NSRC-1:0] en, next_en; // Per-source enables (mask).
	logic gie, next_gie; // Global enable.
	logic [1:0] edge_sel, next_edge_sel; // External edge type.
	logic pull, next_pull; // Pin pull-high select.
	logic [7:0] psc, next_psc; // Prescaler source register.
	logic [7:0] timebase_control, next_tbc; // Time base control register.
	logic [1:0] div4, next_div4; // System clock quarter divider.
	logic lvd_q, next_lvd_q; // Previous low supply level.
	logic pending, next_pending; // Some enabled flag set and global enable on.
	logic [3:0] idx, next_idx; // Winning source index.
	logic [7:0] next_vector; // Winning vector.
	logic next_wake; // Some flag rose.
	logic [7:0] next_rdata; // Read data.
	// ==============================
	// Combinational helpers.
	logic [its_pkg::NSRC-1:0] ev; // Set events this cycle.
	logic [its_pkg::NSRC-1:0] live; // Enabled set flags after update.
	logic ext_rise, ext_fall, sub_rise, high_rise, ext_hit;
	logic [3:0] tick;
	logic [1:0] tb_ovf;

	// ==============================
	// Pin and foreign clock synchronisers.
	its_sync_edge u_ext (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.pin(ext_irq_pin),
		.rise(ext_rise),
		.fall(ext_fall)
	);
	its_sync_edge u_sub (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.pin(sub_clk),
		.rise(sub_rise),
		.fall()
	);
	its_sync_edge u_high (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.pin(high_clk),
		.rise(high_rise),
		.fall()
	);

	// ==============================
	// Prescaler ticks. Sampled clocks must be slower than half the system clock.
	always_comb begin
		next_div4 = div4 + 2'h1;
		tick[its_pkg::SRC_SYS] = 1'b1;
		tick[its_pkg::SRC_SYS4] = (div4 == 2'h3);
		tick[its_pkg::SRC_SUB] = sub_rise;
		tick[its_pkg::SRC_HIGH] = high_rise;
	end

	its_timebase u_tb0 (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.run(timebase_control[its_pkg::TBC_TB0_RUN]),
		.tick(tick),
		.src(psc[its_pkg::PSC_TB0 +: 2]),
		.per(timebase_control[its_pkg::TBC_TB0_PER +: 3]),
		.ovf(tb_ovf[0])
	);
	its_timebase u_tb1 (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.run(timebase_control[its_pkg::TBC_TB1_RUN]),
		.tick(tick),
		.src(psc[its_pkg::PSC_TB1 +: 2]),
		.per(timebase_control[its_pkg::TBC_TB1_PER +: 3]),
		.ovf(tb_ovf[1])
	);

	// ==============================
	// Event collection. The external edge filter is off in the disabled code.
	always_comb begin
		unique case (edge_sel)
			its_pkg::EDGE_RISE: ext_hit = ext_rise;
			its_pkg::EDGE_FALL: ext_hit = ext_fall;
			its_pkg::EDGE_BOTH: ext_hit = ext_rise | ext_fall;
			its_pkg::EDGE_OFF: ext_hit = 1'b0;
		endcase
		next_lvd_q = lvd_low;
		ev = '0;
		ev[its_pkg::S_EXT] = ext_hit;
		ev[its_pkg::S_TB0] = tb_ovf[0];
		ev[its_pkg::S_TB1] = tb_ovf[1];
		ev[its_pkg::S_CTP] = ctm_p_match;
		ev[its_pkg::S_CTA] = ctm_a_match;
		ev[its_pkg::S_PTP1] = ptm_p_match[0];
		ev[its_pkg::S_PTA1] = ptm_a_match[0];
		ev[its_pkg::S_PTP2] = ptm_p_match[1];
		ev[its_pkg::S_PTA2] = ptm_a_match[1];
		ev[its_pkg::S_NV] = nv_write_done;
		// A level held low would refire after each clear, so only its onset counts.
		ev[its_pkg::S_LVD] = lvd_low & ~lvd_q;
		ev[its_pkg::S_AD] = adc_done;
	end

	// ==============================
	// Register writes, service and return. Hardware sets are applied last,
	// so an event in the cycle of a clear is never lost.
	always_comb begin
		next_flag = flag;
		next_en = en;
		next_gie = gie;
		next_edge_sel = edge_sel;
		next_pull = pull;
		next_psc = psc;
		next_tbc = timebase_control;
		if (reg_we) begin
			unique case (reg_addr)
				its_pkg::A_CTRL: begin
					next_gie = reg_wdata[its_pkg::C_GIE];
					next_edge_sel = reg_wdata[its_pkg::C_EDGE +: 2];
					next_pull = reg_wdata[its_pkg::C_PULL];
				end
				// Flags clear by writing one; writing zero leaves them alone.
				its_pkg::A_FLAG_LO: next_flag[7:0] = flag[7:0] & ~reg_wdata;
				its_pkg::A_FLAG_HI: next_flag[11:8] = flag[11:8] & ~reg_wdata[3:0];
				its_pkg::A_EN_LO: next_en[7:0] = reg_wdata;
				its_pkg::A_EN_HI: next_en[11:8] = reg_wdata[3:0];
				its_pkg::A_PSC: next_psc = reg_wdata & its_pkg::PSC_MASK;
				its_pkg::A_TBC: next_tbc = reg_wdata;
				default: begin
					// Unmapped addresses take no write.
				end
			endcase
		end
		if (return_from_irq_instr) begin
			next_gie = 1'b1;
		end
		if (irq_ack && irq_req) begin
			next_flag[idx] = 1'b0;
			next_gie = 1'b0;
		end
		next_flag = next_flag | ev;
		next_wake = |(ev & ~flag);
	end

	// ==============================
	// Priority from the updated state, so the registered request never lags.
	always_comb begin
		live = next_flag & next_en;
		next_pending = next_gie & (|live);
		next_idx = 4'h0;
		next_vector = its_pkg::VEC[0];
		for (int i = its_pkg::NSRC - 1; i >= 0; i--) begin
			if (live[i]) begin
				next_idx = 4'(i);
				next_vector = its_pkg::VEC[i];
			end
		end
	end

	// ==============================
	// Read data for the cycle after the read strobe; reserved bits read zero.
	always_comb begin
		next_rdata = 8'h00;
		if (reg_re) begin
			unique case (reg_addr)
				its_pkg::A_CTRL: next_rdata = {4'h0, pull, edge_sel, gie};
				its_pkg::A_FLAG_LO: next_rdata = flag[7:0];
				its_pkg::A_FLAG_HI: next_rdata = {4'h0, flag[11:8]};
				its_pkg::A_EN_LO: next_rdata = en[7:0];
				its_pkg::A_EN_HI: next_rdata = {4'h0, en[11:8]};
				its_pkg::A_PSC: next_rdata = psc;
				its_pkg::A_TBC: next_rdata = timebase_control;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// ==============================
	// All registers, frozen while the enable is low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag <= '0;
			en <= '0;
			gie <= 1'b0;
			edge_sel <= its_pkg::EDGE_OFF;
			pull <= 1'b0;
			psc <= its_pkg::RST_REG;
			timebase_control <= its_pkg::RST_REG;
			div4 <= 2'h0;
			lvd_q <= 1'b0;
			pending <= 1'b0;
			idx <= 4'h0;
			irq_vector <= 8'h00;
			wake <= 1'b0;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			flag <= next_flag;
			en <= next_en;
			gie <= next_gie;
			edge_sel <= next_edge_sel;
			pull <= next_pull;
			psc <= next_psc;
			timebase_control <= next_tbc;
			div4 <= next_div4;
			lvd_q <= next_lvd_q;
			pending <= next_pending;
			idx <= next_idx;
			irq_vector <= next_vector;
			wake <= next_wake;
			reg_rdata <= next_rdata;
		end
	end

	// The stack check is live so a pop releases the request at once.
	assign irq_req = pending & ~stack_full;
	assign irq = |(flag & en);
	assign ext_pull_high = pull;

	// ==============================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_service;
		ce && irq_ack && irq_req && !return_from_irq_instr;
	endsequence

	AST_EXT_SET: assert property (ce && ext_hit |=> flag[its_pkg::S_EXT])
		else $error("Pin edge did not set external flag.");
	AST_EDGE_OFF: assert property (ce && edge_sel == its_pkg::EDGE_OFF
		&& !flag[its_pkg::S_EXT] |=> !flag[its_pkg::S_EXT])
		else $error("Disabled pin still raised a request.");
	AST_REQ_GATE: assert property (irq_req |-> gie && !stack_full && |(flag & en))
		else $error("Request without enables or with full stack.");
	AST_SERVICE: assert property (s_service |=> !gie
		&& (!flag[$past(idx)] || $past(ev[idx])))
		else $error("Service left flag or global enable set.");
	AST_PULL: assert property (ce && reg_we && reg_addr == its_pkg::A_CTRL
		|=> ext_pull_high == $past(reg_wdata[its_pkg::C_PULL]))
		else $error("Pull-high select not applied.");
	AST_ADC_SET: assert property (ce && adc_done |=> flag[its_pkg::S_AD])
		else $error("Conversion end did not set flag.");
	AST_WAKE: assert property (ce && ev[its_pkg::S_LVD] && !flag[its_pkg::S_LVD]
		|=> wake && flag[its_pkg::S_LVD])
		else $error("Rising flag did not wake.");
	AST_RETURN_FROM_IRQ_INSTR: assert property (ce && return_from_irq_instr && !irq_ack ##1 1 |-> gie)
		else $error("Return did not restore global enable.");
	AST_STICKY: assert property (ce && !irq_ack && !reg_we
		|=> (flag & $past(flag)) == $past(flag))
		else $error("Flag dropped on its own.");
	AST_PRIO: assert property (irq_req && flag[its_pkg::S_EXT] && en[its_pkg::S_EXT]
		|-> irq_vector == its_pkg::VEC[its_pkg::S_EXT])
		else $error("External pin lost priority.");
endmodule
`default_nettype wire

// ---- verilog/its_pkg.sv ----
// Shared constants of the interrupt source and time base block.
`default_nettype none
package its_pkg;
	// ==============================
	// Sources, in priority order (index 0 wins).
	localparam int NSRC = 12;
	localparam int S_EXT = 0;
	localparam int S_TB0 = 1;
	localparam int S_CTP = 2;
	localparam int S_CTA = 3;
	localparam int S_PTP1 = 4;
	localparam int S_PTA1 = 5;
	localparam int S_TB1 = 6;
	localparam int S_NV = 7;
	localparam int S_LVD = 8;
	localparam int S_AD = 9;
	localparam int S_PTP2 = 10;
	localparam int S_PTA2 = 11;
	// Vector address of each source, same order as above.
	localparam logic [NSRC-1:0][7:0] VEC = {8'h3c, 8'h38, 8'h34, 8'h30, 8'h28, 8'h20,
		8'h1c, 8'h18, 8'h14, 8'h10, 8'h0c, 8'h04};
	// ==============================
	// Register indices on the plain register port.
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_FLAG_LO = 4'h1;
	localparam logic [3:0] A_FLAG_HI = 4'h2;
	localparam logic [3:0] A_EN_LO = 4'h3;
	localparam logic [3:0] A_EN_HI = 4'h4;
	localparam logic [3:0] A_PSC = 4'h5;
	localparam logic [3:0] A_TBC = 4'h6;
	// Control register fields.
	localparam int C_GIE = 0;
	localparam int C_EDGE = 1;
	localparam int C_PULL = 3;
	// Edge select codes.
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Prescaler source register: used bits and field positions.
	localparam logic [7:0] PSC_MASK = 8'h33;
	localparam int PSC_TB0 = 0;
	localparam int PSC_TB1 = 4;
	// Time base control register fields.
	localparam int TBC_TB0_PER = 0;
	localparam int TBC_TB0_RUN = 3;
	localparam int TBC_TB1_PER = 4;
	localparam int TBC_TB1_RUN = 7;
	// Prescaler clock source codes.
	localparam logic [1:0] SRC_SYS = 2'h0;
	localparam logic [1:0] SRC_SYS4 = 2'h1;
	localparam logic [1:0] SRC_SUB = 2'h2;
	localparam logic [1:0] SRC_HIGH = 2'h3;
	// Prescaler width and shortest time-out exponent.
	localparam int PSC_W = 15;
	localparam int PER_BASE = 8;
	// Reset values.
	localparam logic [7:0] RST_REG = 8'h00;
endpackage
`default_nettype wire

// ---- verilog/its_sync_edge.sv ----
// Two-stage synchroniser with rise and fall detection for a pin input.
`default_nettype none
`timescale 1ns/1ps
module its_sync_edge (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Asynchronous pin.
	input wire logic pin,
	// Synchronised edges, one-cycle pulses.
	output logic rise,
	output logic fall
);
	// ==============================
	// Stage one feeds only stage two; stage three holds the previous level.
	logic s1, s2, s3;
	logic next_s1, next_s2, next_s3;

	// Next values: a plain shift.
	always_comb begin
		next_s1 = pin;
		next_s2 = s1;
		next_s3 = s2;
	end

	// Registers, frozen while the enable is low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else if (ce) begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
		end
	end

	// Edges compare only the settled stages.
	assign rise = ce & s2 & ~s3;
	assign fall = ce & ~s2 & s3;
endmodule
`default_nettype wire

// ---- verilog/its_timebase.sv ----
// One time base: a 15-bit prescaler with selectable source and time-out.
`default_nettype none
`timescale 1ns/1ps
module its_timebase #(
	parameter int PW = its_pkg::PSC_W,
	parameter int PBASE = its_pkg::PER_BASE
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Configuration.
	input wire logic run,
	input wire logic [3:0] tick,
	input wire logic [1:0] src,
	input wire logic [2:0] per,
	// Time-out, one-cycle pulse.
	output logic ovf
);
	// ==============================
	logic [PW-1:0] cnt, next_cnt;
	logic next_ovf;
	logic step;
	logic [PW-1:0] lim;

	// The count wraps freely; a time-out is the low field all ones on a tick.
	always_comb begin
		step = run & tick[src];
		lim = PW'((32'h1 << (PBASE + int'(per))) - 32'h1);
		next_ovf = step && ((cnt & lim) == lim);
		if (!run) begin
			next_cnt = '0;
		end else if (step) begin
			next_cnt = cnt + 1'b1;
		end else begin
			next_cnt = cnt;
		end
	end

	// Registers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
			ovf <= 1'b0;
		end else if (ce) begin
			cnt <= next_cnt;
			ovf <= next_ovf;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	AST_TB_STOP: assert property (ce && !run |=> cnt == '0 && !ovf)
		else $error("Stopped time base kept counting.");
endmodule
`default_nettype wire
